// *** shared/dcf_defines.vh ***
// Constants for the converter code correction and format block
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH
`define DCF_CODE_W        14
`define DCF_NUM_CH        8
`define DCF_ADDR_W        6
// Word indexes on the register bus
`define DCF_IDX_CONFIG    6'h00
`define DCF_IDX_STATUS    6'h01
`define DCF_IDX_SHIFT_A   6'h02
`define DCF_IDX_SHIFT_B   6'h03
`define DCF_IDX_INPUT     6'h08
`define DCF_IDX_GAIN      6'h10
`define DCF_IDX_ZERO      6'h18
`define DCF_IDX_DATA      6'h20
// Configuration fields
`define DCF_CFG_ENGINE    0
`define DCF_CFG_GAIN4     1
// Status fields
`define DCF_STS_BUSY      0
`define DCF_STS_FORMAT    1
// Reset values and arithmetic constants
`define DCF_GAIN_RESET    14'h2000
`define DCF_ZERO_RESET    14'h0000
`define DCF_INPUT_RESET   14'h0000
`define DCF_GAIN_BIAS     15'h2000
`define DCF_CODE_MAX      17'h03FFF
`define DCF_SHIFT_DEF_G6  14'h2666
`define DCF_SHIFT_DEF_G4  14'h2AAB
`define DCF_INIT_CYCLES   3'h4
`endif

// *** design/dcf_core.v ***
// Code correction engine, data format handling and group shift codes
//
// What this block does
// - Engine on: corrected = input*(gain+2^13)/2^14 plus signed zero trim.
// - Engine off: converter driven from written data register, no trim.
// - One configuration bit selects gain 6 or gain 4 for all channels.
// - Shift code defaults are 9830 for gain 6, 10923 for gain 4.
// - Changing the gain bit reloads both shift codes with the new default.
// - Reset loads gain trims 8192, zero trims 0, input codes 0000h.
// - Format pin low means straight binary, high means twos complement.
// - Straight binary: 0000h lowest, 2000h zero, 3FFFh full scale minus one.
// - Twos complement: 2000h lowest, 0000h zero, 1FFFh top; MSB inverted.
// - Gain trim always straight binary, zero trim always twos complement.
// - Readback returns contents in the encoding they were written in.
// - Two 14-bit shift codes, one per group; higher code shifts negative.
// - After reset shift codes load the default for format and gain.
// - Engine on: each input, gain or zero write reruns the channel's correction.
// - Engine off: trim writes only store values and read back as written.
// - One engine serves all eight channels, calculations are serialized.
// - Channels 0-3 with shift A form group A, 4-7 with shift B group B.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "dcf_defines.vh"

module dcf_core #(
  parameter [13:0] SHIFT_TRIM_A_G6 = `DCF_SHIFT_DEF_G6,
  parameter [13:0] SHIFT_TRIM_A_G4 = `DCF_SHIFT_DEF_G4,
  parameter [13:0] SHIFT_TRIM_B_G6 = `DCF_SHIFT_DEF_G6,
  parameter [13:0] SHIFT_TRIM_B_G4 = `DCF_SHIFT_DEF_G4
) (
  input  wire         clock_in,
  input  wire         rst_in,
  input  wire [5:0]   avs_address_in,
  input  wire         avs_read_in,
  input  wire         avs_write_in,
  input  wire [31:0]  avs_writedata_in,
  output reg  [31:0]  avs_readdata_out,
  output reg          avs_waitrequest_out,
  input  wire         code_format_pin_in,
  output reg  [111:0] conv_codes_out,
  output reg  [13:0]  group_shift_code_a_out,
  output reg  [13:0]  group_shift_code_b_out,
  output reg          gain_sel4_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Straight binary view of a code held in the pin's format
  function [13:0] to_usb;
    input [13:0] code;
    input        twos;
    begin
      to_usb = {code[13] ^ twos, code[12:0]};
    end
  endfunction

  // Default shift code for the gain, encoded in the current format
  function [13:0] shift_default;
    input        gain4;
    input [13:0] def_g6;
    input [13:0] def_g4;
    input        twos;
    begin
      shift_default = to_usb(gain4 ? def_g4 : def_g6, twos);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Format pin synchroniser

  reg  [2:0]  fmt_sync_reg;
  reg         fmt_reg;

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fmt_sync_reg <= 3'h0;
      fmt_reg      <= 1'b0;
    end
    else
    begin
      fmt_sync_reg <= {fmt_sync_reg[1:0], code_format_pin_in};
      if (fmt_sync_reg[1] == fmt_sync_reg[2])
        fmt_reg <= fmt_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg  [13:0] input_mem [0:7];
  reg  [13:0] gain_mem  [0:7];
  reg  [13:0] zero_mem  [0:7];
  reg  [13:0] data_mem  [0:7];
  reg  [13:0] shift_a_reg;
  reg  [13:0] shift_b_reg;
  reg         engine_en_reg;
  reg         gain4_reg;
  reg  [7:0]  pending_reg;
  reg  [2:0]  init_cnt_reg;
  reg         init_reg;

  // Engine state
  localparam  ST_IDLE  = 2'b00;
  localparam  ST_CALC  = 2'b01;
  localparam  ST_STORE = 2'b10;
  reg  [1:0]  state_reg;
  reg  [2:0]  eng_ch_reg;
  reg  [28:0] prod_reg;
  reg  [13:0] zero_cap_reg;
  reg  [13:0] result_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire        accept   = ~avs_waitrequest_out & ~init_reg;
  wire        bus_wr   = accept & avs_write_in;
  wire [2:0]  ch_sel   = avs_address_in[2:0];
  wire [2:0]  bank     = avs_address_in[5:3];
  wire        wr_input = bus_wr & (bank == 3'h1);
  wire        wr_gain  = bus_wr & (bank == 3'h2);
  wire        wr_zero  = bus_wr & (bank == 3'h3);
  wire        wr_data  = bus_wr & (bank == 3'h4);
  wire        wr_cfg   = bus_wr & (avs_address_in == `DCF_IDX_CONFIG);
  wire        new_gain4 = avs_writedata_in[`DCF_CFG_GAIN4];
  wire        trim_wr  = (wr_input | wr_gain | wr_zero) & engine_en_reg;

  reg  [31:0] rd_next;

  always @*
  begin
    rd_next = 32'h0000_0000;
    if (avs_address_in == `DCF_IDX_CONFIG)
      rd_next = {30'h0, gain4_reg, engine_en_reg};
    else if (avs_address_in == `DCF_IDX_STATUS)
      rd_next = {30'h0, fmt_reg, (state_reg != ST_IDLE) | (|pending_reg)};
    else if (avs_address_in == `DCF_IDX_SHIFT_A)
      rd_next = {18'h0, shift_a_reg};
    else if (avs_address_in == `DCF_IDX_SHIFT_B)
      rd_next = {18'h0, shift_b_reg};
    else if (bank == 3'h1)
      rd_next = {18'h0, input_mem[ch_sel]};
    else if (bank == 3'h2)
      rd_next = {18'h0, gain_mem[ch_sel]};
    else if (bank == 3'h3)
      rd_next = {18'h0, zero_mem[ch_sel]};
    else if (bank == 3'h4)
      rd_next = {18'h0, data_mem[ch_sel]};
  end

  // Waitrequest falls for exactly one cycle per request, so every access
  // costs two edges but the output stays a plain flop.
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_out <= 1'b1;
      if ((avs_read_in | avs_write_in) & avs_waitrequest_out & ~init_reg)
      begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= rd_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and shift codes

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      engine_en_reg <= 1'b0;
      gain4_reg     <= 1'b0;
      shift_a_reg   <= `DCF_SHIFT_DEF_G6;
      shift_b_reg   <= `DCF_SHIFT_DEF_G6;
      init_cnt_reg  <= 3'h0;
      init_reg      <= 1'b1;
    end
    else
    begin
      // Shift defaults depend on the pin, so they load once it has settled
      if (init_reg)
      begin
        init_cnt_reg <= init_cnt_reg + 3'h1;
        if (init_cnt_reg == `DCF_INIT_CYCLES)
        begin
          init_reg    <= 1'b0;
          shift_a_reg <= shift_default(gain4_reg, SHIFT_TRIM_A_G6,
                                       SHIFT_TRIM_A_G4, fmt_reg);
          shift_b_reg <= shift_default(gain4_reg, SHIFT_TRIM_B_G6,
                                       SHIFT_TRIM_B_G4, fmt_reg);
        end
      end
      if (wr_cfg)
      begin
        engine_en_reg <= avs_writedata_in[`DCF_CFG_ENGINE];
        gain4_reg     <= new_gain4;
        if (new_gain4 != gain4_reg)
        begin
          shift_a_reg <= shift_default(new_gain4, SHIFT_TRIM_A_G6,
                                       SHIFT_TRIM_A_G4, fmt_reg);
          shift_b_reg <= shift_default(new_gain4, SHIFT_TRIM_B_G6,
                                       SHIFT_TRIM_B_G4, fmt_reg);
        end
      end
      else if (bus_wr & (avs_address_in == `DCF_IDX_SHIFT_A))
        shift_a_reg <= avs_writedata_in[13:0];
      else if (bus_wr & (avs_address_in == `DCF_IDX_SHIFT_B))
        shift_b_reg <= avs_writedata_in[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers and shared engine

  reg  [2:0]  pick;
  reg         pick_ok;
  integer     k;
  integer     j;
  integer     m;

  always @*
  begin
    pick    = 3'h0;
    pick_ok = 1'b0;
    for (k = 7; k >= 0; k = k - 1)
    begin
      if (pending_reg[k])
      begin
        pick    = k[2:0];
        pick_ok = 1'b1;
      end
    end
  end

  wire [13:0] in_usb  = to_usb(input_mem[eng_ch_reg], fmt_reg);
  wire [14:0] gain_f  = {1'b0, gain_mem[eng_ch_reg]} + `DCF_GAIN_BIAS;
  wire [16:0] sum_s   = {2'b00, prod_reg[28:14]} +
                        {{3{zero_cap_reg[13]}}, zero_cap_reg};
  reg  [13:0] sat_code;

  always @*
  begin
    if (sum_s[16])
      sat_code = 14'h0000;
    else if (sum_s > `DCF_CODE_MAX)
      sat_code = 14'h3FFF;
    else
      sat_code = sum_s[13:0];
  end

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        input_mem[j] <= `DCF_INPUT_RESET;
        gain_mem[j]  <= `DCF_GAIN_RESET;
        zero_mem[j]  <= `DCF_ZERO_RESET;
        data_mem[j]  <= `DCF_INPUT_RESET;
      end
      pending_reg  <= 8'h00;
      state_reg    <= ST_IDLE;
      eng_ch_reg   <= 3'h0;
      prod_reg     <= 29'h0000_0000;
      zero_cap_reg <= 14'h0000;
      result_reg   <= 14'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (pick_ok)
          begin
            eng_ch_reg <= pick;
            pending_reg[pick] <= 1'b0;
            state_reg  <= ST_CALC;
          end
        end
        ST_CALC:
        begin
          prod_reg     <= in_usb * gain_f;
          zero_cap_reg <= zero_mem[eng_ch_reg];
          state_reg    <= ST_STORE;
        end
        ST_STORE:
        begin
          // Stored in the pin's format so readback matches what software writes
          data_mem[eng_ch_reg] <= to_usb(sat_code, fmt_reg);
          result_reg <= sat_code;
          state_reg  <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
      // A write landing as the engine takes the channel sets it again
      if (trim_wr)
        pending_reg[ch_sel] <= 1'b1;
      if (wr_input)
        input_mem[ch_sel] <= avs_writedata_in[13:0];
      if (wr_gain)
        gain_mem[ch_sel] <= avs_writedata_in[13:0];
      if (wr_zero)
        zero_mem[ch_sel] <= avs_writedata_in[13:0];
      if (wr_data)
        data_mem[ch_sel] <= avs_writedata_in[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the converter core, all straight binary

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conv_codes_out         <= {112{1'b0}};
      group_shift_code_a_out <= `DCF_SHIFT_DEF_G6;
      group_shift_code_b_out <= `DCF_SHIFT_DEF_G6;
      gain_sel4_out          <= 1'b0;
    end
    else
    begin
      for (m = 0; m < 8; m = m + 1)
        conv_codes_out[m*14 +: 14] <= to_usb(data_mem[m], fmt_reg);
      group_shift_code_a_out <= to_usb(shift_a_reg, fmt_reg);
      group_shift_code_b_out <= to_usb(shift_b_reg, fmt_reg);
      gain_sel4_out          <= gain4_reg;
    end
  end

endmodule

// *** testbench/dcf_core_asserts.sv ***
// Port checks for the code correction block
`timescale 1ns/1ns
module dcf_core_asserts (
  input wire         clock_in,
  input wire         rst_in,
  input wire [5:0]   avs_address_in,
  input wire         avs_read_in,
  input wire         avs_write_in,
  input wire [31:0]  avs_writedata_in,
  input wire         avs_waitrequest_out,
  input wire         code_format_pin_in,
  input wire [111:0] conv_codes_out,
  input wire [13:0]  group_shift_code_a_out,
  input wire [13:0]  group_shift_code_b_out,
  input wire         gain_sel4_out
);
  reg        wr_hit_reg;
  reg [5:0]  wr_idx_reg;
  reg [13:0] wr_d_reg;
  wire [13:0] mask = {code_format_pin_in, 13'h0000};
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////
  // Last accepted write; the bench holds the format pin steady around writes
  always @(posedge clock_in or posedge rst_in)
    if (rst_in)
      wr_hit_reg <= 1'b0;
    else
    begin
      wr_hit_reg <= avs_write_in && !avs_waitrequest_out;
      wr_idx_reg <= avs_address_in;
      wr_d_reg   <= avs_writedata_in[13:0];
    end
  sequence s_wr(logic [5:0] idx); wr_hit_reg && wr_idx_reg == idx; endsequence
  ////////////////////////////////////////////////////////////////
  property p_wait_pulse; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_wait_cause;
    $fell(avs_waitrequest_out) |-> $past(avs_read_in) || $past(avs_write_in);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_reset_shift;
    $fell(rst_in) |-> ##[5:9] group_shift_code_a_out == 14'h2666
      && group_shift_code_b_out == 14'h2666;
  endproperty
  a_reset_shift: assert property (p_reset_shift) else $error("shift default");
  property p_gain4;
    $rose(gain_sel4_out) |-> ##[0:2] group_shift_code_a_out == 14'h2AAB
      && group_shift_code_b_out == 14'h2AAB;
  endproperty
  a_gain4: assert property (p_gain4) else $error("no reload on gain 4");
  property p_gain6;
    $fell(gain_sel4_out) |-> ##[0:2] group_shift_code_a_out == 14'h2666
      && group_shift_code_b_out == 14'h2666;
  endproperty
  a_gain6: assert property (p_gain6) else $error("no reload on gain 6");
  property p_cfg; s_wr(6'h00) |-> ##[0:1] gain_sel4_out == wr_d_reg[1]; endproperty
  a_cfg: assert property (p_cfg) else $error("gain select");
  property p_shift_a;
    s_wr(6'h02) |-> ##[0:1] group_shift_code_a_out == (wr_d_reg ^ mask);
  endproperty
  a_shift_a: assert property (p_shift_a) else $error("shift A code");
  property p_shift_b;
    s_wr(6'h03) |-> ##[0:1] group_shift_code_b_out == (wr_d_reg ^ mask);
  endproperty
  a_shift_b: assert property (p_shift_b) else $error("shift B code");
  property p_data0; s_wr(6'h20) |-> ##[0:1] conv_codes_out[13:0] == (wr_d_reg ^ mask); endproperty
  a_data0: assert property (p_data0) else $error("direct data path");
endmodule
bind dcf_core dcf_core_asserts dcf_core_asserts_i (.*);

// *** testbench/dcf_host.sv ***
// Register bus master standing in for the host controller
`timescale 1ns/1ns
module dcf_host (
  input  wire        clock_in,
  input  wire        avs_waitrequest_in,
  input  wire [31:0] avs_readdata_in,
  output reg  [5:0]  avs_address_out = 6'h00,
  output reg         avs_read_out = 1'b0,
  output reg         avs_write_out = 1'b0,
  output reg  [31:0] avs_writedata_out = 32'h00000000,
  output reg         rd_valid_out = 1'b0,
  output reg  [31:0] rd_data_out = 32'h00000000,
  output reg         hung_out = 1'b0
);
  // Read data is taken at the very edge that sees waitrequest low
  always @(posedge clock_in)
  begin
    rd_valid_out <= avs_read_out && avs_waitrequest_in === 1'b0;
    rd_data_out  <= avs_readdata_in;
  end
  // Request held until accepted; one idle cycle after keeps drivers single per step
  task xfer(input reg wr, input reg [5:0] a, input reg [31:0] d);
    integer n;
    begin
      avs_address_out <= a;
      avs_read_out <= !wr;
      avs_write_out <= wr;
      avs_writedata_out <= d;
      n = 0;
      @(posedge clock_in);
      while (avs_waitrequest_in !== 1'b0 && n < 40)
      begin
        @(posedge clock_in);
        n = n + 1;
      end
      hung_out <= hung_out || n >= 40;
      avs_read_out <= 1'b0;
      avs_write_out <= 1'b0;
      @(posedge clock_in);
    end
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the code correction block
`timescale 1ns/1ns
module tb;
  reg          clock_in = 1'b0;
  reg          rst_in = 1'b1;
  reg          code_format_pin_in = 1'b0;
  wire [5:0]   addr;
  wire         rd_s, wr_s, wait_s, rd_valid, hung;
  wire [31:0]  wdata, rdata, rd_data;
  wire [111:0] codes;
  reg  [13:0]  ex;
  integer      mismatches = 0;
  integer      n_compared = 0;
  integer      seed = 32'hAB6910C3;
  reg  [31:0]  r;
  reg  [31:0]  exp_q[$];
  reg  [13:0]  g[0:7], z[0:7], u[0:7];
  reg  [5:0]   c;
  reg  [1:0]   f;
  dcf_core dcf_core_i (.clock_in(clock_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s),
    .code_format_pin_in(code_format_pin_in), .conv_codes_out(codes), .group_shift_code_a_out(),
    .group_shift_code_b_out(), .gain_sel4_out());
  dcf_host dcf_host_i (.clock_in(clock_in), .avs_waitrequest_in(wait_s), .avs_readdata_in(rdata),
    .avs_address_out(addr), .avs_read_out(rd_s), .avs_write_out(wr_s), .avs_writedata_out(wdata),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .hung_out(hung));
  initial forever #5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task wr(input reg [5:0] a, input reg [13:0] d);
    dcf_host_i.xfer(1'b1, a, {18'h00000, d});
  endtask
  task rd(input reg [5:0] a, input reg [13:0] e);
    begin
      exp_q.push_back({18'h00000, e});
      dcf_host_i.xfer(1'b0, a, 32'h00000000);
    end
  endtask
  // Saturates rather than wraps, so out-of-range trims clip at the rails
  function [13:0] corr(input [13:0] i, input [13:0] gn, input [13:0] zr, input fm);
    reg [28:0] p;
    reg [16:0] s;
    begin
      p = (i ^ {fm, 13'h0000}) * (gn + 29'h00002000);
      s = {2'h0, p[28:14]} + {{3{zr[13]}}, zr};
      if (s[16]) corr = 14'h0000;
      else if (s > 17'h03FFF) corr = 14'h3FFF;
      else corr = s[13:0];
      corr = corr ^ {fm, 13'h0000};
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  always @(posedge clock_in)
  begin
    if (hung)
    begin
      mismatches = mismatches + 1;
      final_report;
    end
    if (rd_valid)
    begin
      n_compared = n_compared + 1;
      if (exp_q.size() == 0 || rd_data !== exp_q[0])
      begin
        mismatches = mismatches + 1;
        $display("Error at %0t: read %h", $time, rd_data);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (20000) @(posedge clock_in);
    mismatches = mismatches + 1;
    final_report;
  end
  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    for (c = 0; c < 6'h08; c = c + 1)
    begin
      rd(6'h08 + c, 14'h0000);
      rd(6'h10 + c, 14'h2000);
      rd(6'h18 + c, 14'h0000);
    end
    rd(6'h03, 14'h2666);
    wr(6'h3F, 14'h1234);
    rd(6'h3F, 14'h0000);
    $display("Test reset values done");
    wr(6'h11, 14'h0155);
    wr(6'h19, 14'h3ABC);
    wr(6'h20, 14'h1357);
    wr(6'h08, 14'h0777);
    rd(6'h19, 14'h3ABC);
    rd(6'h21, 14'h0000);
    rd(6'h20, 14'h1357);
    wr(6'h02, 14'h0123);
    wr(6'h03, 14'h0456);
    rd(6'h02, 14'h0123);
    rd(6'h03, 14'h0456);
    wr(6'h00, 14'h0002);
    rd(6'h02, 14'h2AAB);
    wr(6'h00, 14'h0000);
    rd(6'h03, 14'h2666);
    $display("Test engine off and gain reload done");
    for (f = 0; f < 2'h2; f = f + 1)
    begin
      code_format_pin_in <= f[0];
      repeat (8) @(posedge clock_in);
      wr(6'h00, 14'h0001);
      for (c = 0; c < 6'h08; c = c + 1)
      begin
        r = $random(seed);
        {g[c], z[c], u[c]} = {r[13:0], r[27:14], r[31:18]};
      end
      {g[0], z[0], u[0]} = {14'h3FFF, 14'h1FFF, 14'h3FFF ^ {f[0], 13'h0000}};
      {z[1], u[1]} = {14'h2000, {f[0], 13'h0000}};
      for (c = 0; c < 6'h08; c = c + 1)
      begin
        wr(6'h10 + c, g[c]);
        wr(6'h18 + c, z[c]);
        wr(6'h08 + c, u[c]);
      end
      repeat (30) @(posedge clock_in);
      rd(6'h01, {12'h000, f[0], 1'b0});
      for (c = 0; c < 6'h08; c = c + 1)
      begin
        rd(6'h20 + c, corr(u[c], g[c], z[c], f[0]));
        rd(6'h08 + c, u[c]);
        rd(6'h18 + c, z[c]);
        // The converter always sees straight binary, whatever the pin says
        ex = corr(u[c], g[c], z[c], f[0]) ^ {f[0], 13'h0000};
        n_compared = n_compared + 1;
        if (codes[c*14 +: 14] !== ex)
        begin
          mismatches = mismatches + 1;
          $display("Error at %0t: converter code of channel %0d", $time, c);
        end
      end
      $display("Test engine in format %0d done", f);
    end
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(6'h02, 14'h0666);
    // Let the checking process see the last answer before the verdict
    repeat (2) @(posedge clock_in);
    if (exp_q.size() != 0)
    begin
      mismatches = mismatches + 1;
      $display("Error at %0t: %0d reads unanswered", $time, exp_q.size());
    end
    $display("Test twos complement reset done");
    final_report;
  end
endmodule
